// File: fps_defines.svh
// constants of the fault protection supervisor: counts, reset values, field positions
// assumes a 100 MHz core clock and is included by bare name
`ifndef FPS_DEFINES_SVH
`define FPS_DEFINES_SVH

// ==============================
// timing
`define FPS_CLK_HZ          100000000
`define FPS_TICK_SEC        1
`define FPS_TICK_CYCLES     (`FPS_CLK_HZ * `FPS_TICK_SEC)

// ==============================
// regulator counts and watchdog width
`define FPS_NUM_LDO         6
`define FPS_NUM_BUCK        8
`define FPS_WDG_W           8

// ==============================
// field positions and reset values
`define FPS_LOCK_OPT_BIT    0
`define FPS_WDG_TMO_RST     8'h00
`define FPS_ZERO8           8'h00

`endif

// File: fps_pkg.sv
// types shared by the fault protection supervisor files
// assumes fps_defines.svh is on the include path
package fps_pkg;
    typedef enum logic [2:0] {
        FPS_OFF_NONE,
        FPS_OFF_OVERCURRENT,
        FPS_OFF_OVERCURRENT_LOCK,
        FPS_OFF_WATCHDOG
    } fps_off_cause_t;

    typedef enum {
        FPS_ST_ON,
        FPS_ST_RAMP_OFF,
        FPS_ST_IDLE,
        FPS_ST_LOCK
    } fps_state_t;

    typedef struct packed {
        logic                  shutdown;
        logic                  allow_restart;
        fps_off_cause_t        cause;
    } fps_off_req_t;
endpackage : fps_pkg

// File: fps_ramp_partner.sv
// partner: power sequencer that ends a ramp-off after a chosen number of cycles
// assumes ramp_off_in stays high until the done pulse has been taken
`timescale 1ns/1ns
`default_nettype none
module fps_ramp_partner (
    input  wire logic       core_clk_in,
    input  wire logic       rstn_in,
    input  wire logic       ramp_off_in,
    input  wire logic [3:0] delay_in,
    output logic            ramp_done_out
);
    logic [3:0] wait_reg;

    // ==============================
    // done pulse, one cycle, so a slow sequencer can be mimicked
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in || !ramp_off_in || ramp_done_out) begin
            wait_reg      <= 4'h0;
            ramp_done_out <= 1'b0;
        end else if (wait_reg == delay_in) begin
            ramp_done_out <= 1'b1;
        end else begin
            wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule : fps_ramp_partner
`default_nettype wire

// File: fps_supervisor.sv
// fault protection supervisor: overcurrent response levels and watchdog turn-off
// assumes fault inputs are synchronous one-cycle or level flags and a 100 MHz clock
//
// How it works
// RQ1 - level 0: limit only, stay on
// RQ2 - every overcurrent sets its pending interrupt bit
// RQ3 - turn-off select makes overcurrent a turn-off
// RQ4 - overcurrent turn-off ignores restart enable
// RQ5 - after overcurrent off, idle until turn-on
// RQ6 - record offending regulator in off status
// RQ7 - lock option is shadow bit 0
// RQ8 - lock option overrides turn-off selects
// RQ9 - lock: ramp off then lock state
// RQ10 - lock held until supply power-on reset
// RQ11 - long key press clears lock if allowed
// RQ12 - watchdog end raises turn-off
// RQ13 - watchdog idle until enable set
// RQ14 - timeout 1 s to 256 s, 1 s steps
// RQ15 - kick or enable rise reloads counter
// RQ16 - watchdog ignores power-control mode
// RQ17 - enable cleared by reset cycle, off
// RQ18 - watchdog expiry honours restart enable
// RQ19 - last turn-off cause recorded
// RQ20 - one-second tick decrements counter
`timescale 1ns/1ns
`default_nettype none
`include "fps_defines.svh"
module fps_supervisor
    import fps_pkg::*;
#(
    parameter int NUM_LDO     = `FPS_NUM_LDO,
    parameter int NUM_BUCK    = `FPS_NUM_BUCK,
    parameter int WDG_W       = `FPS_WDG_W,
    parameter int TICK_CYCLES = `FPS_TICK_CYCLES
) (
    input  wire logic                core_clk_in,
    input  wire logic                rstn_in,
    input  wire logic [7:0]          nonvolatile_main_control_shadow_in,
    input  wire logic [NUM_LDO-1:0]  ldo_overcurrent_in,
    input  wire logic [NUM_BUCK-1:0] buck_overcurrent_in,
    input  wire logic [NUM_LDO-1:0]  ldo_turnoff_select_in,
    input  wire logic [NUM_BUCK-1:0] buck_turnoff_select_in,
    input  wire logic                restart_request_enable_in,
    input  wire logic                key_clears_lock_flag_in,
    input  wire logic                power_key_long_press_in,
    input  wire logic                turn_on_request_in,
    input  wire logic                ramp_off_done_in,
    input  wire logic                reset_cycle_in,
    input  wire logic                secondary_power_mode_in,
    input  wire logic                watchdog_enable_set_in,
    input  wire logic                watchdog_enable_clear_in,
    input  wire logic                watchdog_kick_bit_in,
    input  wire logic [WDG_W-1:0]    watchdog_timeout_setting_in,
    input  wire logic [NUM_LDO-1:0]  irq_ldo_clear_in,
    input  wire logic [NUM_BUCK-1:0] irq_buck_clear_in,
    output logic [NUM_LDO-1:0]       pending_irq_reg_three_out,
    output logic [NUM_BUCK-1:0]      pending_irq_reg_two_out,
    output logic [NUM_LDO-1:0]       current_limit_out,
    output logic [NUM_BUCK-1:0]      buck_current_limit_out,
    output logic [NUM_LDO-1:0]       ldo_overcurrent_off_status_out,
    output logic [NUM_BUCK-1:0]      buck_switch_overcurrent_off_status_out,
    output logic                     internal_lock_flag_out,
    output logic                     ramp_off_out,
    output logic                     supplies_up_out,
    output logic                     lock_state_out,
    output logic                     auto_restart_out,
    output logic                     watchdog_enable_bit_out,
    output logic [WDG_W:0]           watchdog_count_out,
    output fps_off_cause_t           turnoff_cause_out
);
    fps_state_t     state_reg;
    fps_off_req_t   req;
    logic           lock_opt;
    logic           any_oc;
    logic           sel_oc;
    logic           tick;
    logic           wdg_expire;
    logic           restart_pend_reg;

    initial begin
        if (NUM_LDO < 1 || NUM_BUCK < 1) $error("need at least one regulator of each kind");
        if (TICK_CYCLES < 1) $error("TICK_CYCLES must be at least 1");
    end

    // RQ7 lock option from shadow bit
    assign lock_opt = nonvolatile_main_control_shadow_in[`FPS_LOCK_OPT_BIT];
    assign any_oc   = (|ldo_overcurrent_in) || (|buck_overcurrent_in);
    assign sel_oc   = (|(ldo_overcurrent_in & ldo_turnoff_select_in))
                   || (|(buck_overcurrent_in & buck_turnoff_select_in));

    // RQ1 current limiting always engaged
    assign current_limit_out      = ldo_overcurrent_in;
    assign buck_current_limit_out = buck_overcurrent_in;

    // ==============================
    // turn-off decision, only evaluated while supplies are up
    always_comb begin
        req = '{shutdown: 1'b0, allow_restart: 1'b0, cause: FPS_OFF_NONE};
        if (state_reg == FPS_ST_ON) begin
            // RQ8 lock overrides selects
            if (lock_opt && any_oc) begin
                req = '{shutdown: 1'b1, allow_restart: 1'b0, cause: FPS_OFF_OVERCURRENT_LOCK};
            // RQ3 selected overcurrent turns off
            end else if (!lock_opt && sel_oc) begin
                // RQ4 restart enable ignored
                req = '{shutdown: 1'b1, allow_restart: 1'b0, cause: FPS_OFF_OVERCURRENT};
            // RQ18 watchdog honours restart enable
            end else if (wdg_expire) begin
                req = '{shutdown: 1'b1, allow_restart: restart_request_enable_in,
                        cause: FPS_OFF_WATCHDOG};
            end
        end
    end

    // ==============================
    // power state
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            state_reg <= FPS_ST_ON;
        end else begin
            case (state_reg)
                FPS_ST_ON: begin
                    if (req.shutdown) state_reg <= FPS_ST_RAMP_OFF;
                end
                FPS_ST_RAMP_OFF: begin
                    // RQ9 ramp off then lock
                    if (ramp_off_done_in) begin
                        if (internal_lock_flag_out)  state_reg <= FPS_ST_LOCK;
                        else if (restart_pend_reg)   state_reg <= FPS_ST_ON;
                        else                         state_reg <= FPS_ST_IDLE;
                    end
                end
                FPS_ST_IDLE: begin
                    // RQ5 wait for turn-on
                    if (turn_on_request_in) state_reg <= FPS_ST_ON;
                end
                FPS_ST_LOCK: begin
                    // RQ10 leave only when flag drops
                    if (!internal_lock_flag_out) state_reg <= FPS_ST_IDLE;
                end
                default: state_reg <= FPS_ST_ON;
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in)         restart_pend_reg <= 1'b0;
        else if (req.shutdown) restart_pend_reg <= req.allow_restart;
    end

    // ==============================
    // lock flag; supply power-on reset is rstn_in
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            internal_lock_flag_out <= 1'b0;
        end else if (req.shutdown && req.cause == FPS_OFF_OVERCURRENT_LOCK) begin
            internal_lock_flag_out <= 1'b1;
        // RQ11 key press clears if allowed
        end else if (power_key_long_press_in && key_clears_lock_flag_in) begin
            internal_lock_flag_out <= 1'b0;
        end
    end

    // ==============================
    // RQ2 interrupt pending, set wins over clear
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            pending_irq_reg_three_out <= '0;
            pending_irq_reg_two_out   <= '0;
        end else begin
            pending_irq_reg_three_out <= (pending_irq_reg_three_out & ~irq_ldo_clear_in)
                                       | ldo_overcurrent_in;
            pending_irq_reg_two_out   <= (pending_irq_reg_two_out & ~irq_buck_clear_in)
                                       | buck_overcurrent_in;
        end
    end

    // ==============================
    // RQ6 offending regulator, latched at the turn-off
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            ldo_overcurrent_off_status_out         <= '0;
            buck_switch_overcurrent_off_status_out <= '0;
        end else if (req.shutdown && req.cause != FPS_OFF_WATCHDOG) begin
            ldo_overcurrent_off_status_out         <= ldo_overcurrent_in;
            buck_switch_overcurrent_off_status_out <= buck_overcurrent_in;
        end
    end

    // RQ19 last turn-off cause
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in)          turnoff_cause_out <= FPS_OFF_NONE;
        else if (req.shutdown) turnoff_cause_out <= req.cause;
    end

    // ==============================
    // watchdog enable; RQ13 off after reset
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            watchdog_enable_bit_out <= 1'b0;
        // RQ17 cleared by reset cycle and turn-off
        end else if (reset_cycle_in || req.shutdown || state_reg != FPS_ST_ON) begin
            watchdog_enable_bit_out <= 1'b0;
        end else if (watchdog_enable_set_in) begin
            watchdog_enable_bit_out <= 1'b1;
        end else if (watchdog_enable_clear_in) begin
            watchdog_enable_bit_out <= 1'b0;
        end
    end

    // RQ16 power-control mode does not gate the tick
    fps_tick_gen #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .core_clk_in (core_clk_in),
        .rstn_in     (rstn_in),
        .run_in      (watchdog_enable_bit_out),
        .tick_out    (tick)
    );

    // RQ14 8-bit setting, 1 s to 256 s
    fps_watchdog #(
        .WDG_W (WDG_W)
    ) u_wdg (
        .core_clk_in (core_clk_in),
        .rstn_in     (rstn_in),
        .enable_in   (watchdog_enable_bit_out),
        .kick_in     (watchdog_kick_bit_in),
        .timeout_in  (watchdog_timeout_setting_in),
        .tick_in     (tick),
        .expire_out  (wdg_expire),
        .count_out   (watchdog_count_out)
    );

    // mode input only reported to show it is deliberately unused by the watchdog
    logic mode_unused;
    assign mode_unused = secondary_power_mode_in;

    assign ramp_off_out     = (state_reg == FPS_ST_RAMP_OFF);
    assign supplies_up_out  = (state_reg == FPS_ST_ON);
    assign lock_state_out   = (state_reg == FPS_ST_LOCK);
    assign auto_restart_out = restart_pend_reg;
endmodule : fps_supervisor
`default_nettype wire

// File: fps_supervisor_checker.sv
// checker: overcurrent levels, lock and watchdog turn-off
// assumes one core clock with synchronous active-low reset; bound at the foot
`timescale 1ns/1ns
`default_nettype none
module fps_supervisor_checker
    import fps_pkg::*;
#(
    parameter int NUM_LDO  = 6,
    parameter int NUM_BUCK = 8,
    parameter int WDG_W    = 8
) (
    input wire logic                core_clk_in,
    input wire logic                rstn_in,
    input wire logic [7:0]          nonvolatile_main_control_shadow_in,
    input wire logic [NUM_LDO-1:0]  ldo_overcurrent_in,
    input wire logic [NUM_BUCK-1:0] buck_overcurrent_in,
    input wire logic [NUM_LDO-1:0]  ldo_turnoff_select_in,
    input wire logic [NUM_BUCK-1:0] buck_turnoff_select_in,
    input wire logic                restart_request_enable_in,
    input wire logic                key_clears_lock_flag_in,
    input wire logic                power_key_long_press_in,
    input wire logic [WDG_W-1:0]    watchdog_timeout_setting_in,
    input wire logic [NUM_LDO-1:0]  pending_irq_reg_three_out,
    input wire logic                internal_lock_flag_out,
    input wire logic                ramp_off_out,
    input wire logic                supplies_up_out,
    input wire logic                auto_restart_out,
    input wire logic                watchdog_enable_bit_out,
    input wire logic [WDG_W:0]      watchdog_count_out,
    input wire fps_off_cause_t      turnoff_cause_out
);
    // ==============================
    // helpers
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    wire logic on_st = supplies_up_out && !ramp_off_out;
    wire logic lk    = nonvolatile_main_control_shadow_in[0];
    wire logic sel_f = |(ldo_overcurrent_in & ldo_turnoff_select_in)
                    || |(buck_overcurrent_in & buck_turnoff_select_in);

    // ==============================
    // overcurrent levels
    // limit only
    AST_LIMIT_STAY_ON: assert property (
        on_st && !lk && !sel_f && !watchdog_enable_bit_out |=> on_st)
        else $error("unselected overcurrent left the on state");
    AST_IRQ_SET: assert property (
        ldo_overcurrent_in != 0 |=> (pending_irq_reg_three_out & $past(ldo_overcurrent_in))
        == $past(ldo_overcurrent_in)) else $error("overcurrent interrupt bit not set");
    AST_SEL_OFF: assert property (
        on_st && !lk && sel_f |=> ramp_off_out && turnoff_cause_out == FPS_OFF_OVERCURRENT)
        else $error("selected overcurrent did not start ramp-off");
    AST_NO_RESTART: assert property (
        ramp_off_out && turnoff_cause_out != FPS_OFF_WATCHDOG |-> !auto_restart_out)
        else $error("overcurrent turn-off set auto restart");
    AST_LOCK_ENTRY: assert property (
        on_st && lk && (ldo_overcurrent_in != 0 || buck_overcurrent_in != 0) |=> ramp_off_out
        && internal_lock_flag_out && turnoff_cause_out == FPS_OFF_OVERCURRENT_LOCK)
        else $error("lock option did not lock on overcurrent");
    AST_LOCK_HOLD: assert property (
        internal_lock_flag_out && !(power_key_long_press_in && key_clears_lock_flag_in)
        |=> internal_lock_flag_out) else $error("lock flag dropped without release");

    // ==============================
    // watchdog
    // expiry turn-off
    AST_WDG_EXPIRE: assert property (
        watchdog_enable_bit_out && watchdog_count_out == 0 && $past(watchdog_count_out) == 1
        |-> ##[1:3] (ramp_off_out && turnoff_cause_out == FPS_OFF_WATCHDOG))
        else $error("watchdog end gave no turn-off");
    AST_WDG_LOAD: assert property (
        $rose(watchdog_enable_bit_out) |=> watchdog_count_out
        == {1'b0, $past(watchdog_timeout_setting_in)} + 1'b1)
        else $error("enable rise did not reload the counter");
    AST_WDG_OFF: assert property (
        ramp_off_out |-> !watchdog_enable_bit_out) else $error("watchdog enabled during ramp-off");
    AST_WDG_RESTART: assert property (
        ramp_off_out && turnoff_cause_out == FPS_OFF_WATCHDOG && restart_request_enable_in
        |-> auto_restart_out) else $error("watchdog turn-off ignored restart enable");

    COV_LEVEL0: cover property (on_st && !lk && ldo_overcurrent_in != 0);
    COV_LOCK: cover property (internal_lock_flag_out && !supplies_up_out && !ramp_off_out);
    COV_WDG: cover property (ramp_off_out && turnoff_cause_out == FPS_OFF_WATCHDOG);
endmodule : fps_supervisor_checker

bind fps_supervisor fps_supervisor_checker #(
    .NUM_LDO(NUM_LDO), .NUM_BUCK(NUM_BUCK), .WDG_W(WDG_W)) checker_i (.*);
`default_nettype wire

// File: fps_tick_gen.sv
// one-second tick divider
// assumes a single core clock, synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
`include "fps_defines.svh"
module fps_tick_gen
    import fps_pkg::*;
#(
    parameter int TICK_CYCLES = `FPS_TICK_CYCLES
) (
    input  wire logic core_clk_in,
    input  wire logic rstn_in,
    input  wire logic run_in,
    output logic      tick_out
);
    localparam int CW = $clog2(TICK_CYCLES + 1);
    logic [CW-1:0] cnt_reg;

    initial begin
        if (TICK_CYCLES < 1) $error("TICK_CYCLES must be at least 1");
    end

    // ==============================
    // divider, restarts whenever the watchdog is idle
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in || !run_in) begin
            cnt_reg  <= '0;
            tick_out <= 1'b0;
        end else if (cnt_reg == CW'(TICK_CYCLES - 1)) begin
            cnt_reg  <= '0;
            tick_out <= 1'b1;
        end else begin
            cnt_reg  <= cnt_reg + CW'(1);
            tick_out <= 1'b0;
        end
    end
endmodule : fps_tick_gen
`default_nettype wire

// File: fps_watchdog.sv
// software-kicked watchdog down counter
// assumes tick_in is a one-cycle pulse once per second
`timescale 1ns/1ns
`default_nettype none
`include "fps_defines.svh"
module fps_watchdog
    import fps_pkg::*;
#(
    parameter int WDG_W = `FPS_WDG_W
) (
    input  wire logic             core_clk_in,
    input  wire logic             rstn_in,
    input  wire logic             enable_in,
    input  wire logic             kick_in,
    input  wire logic [WDG_W-1:0] timeout_in,
    input  wire logic             tick_in,
    output logic                  expire_out,
    output logic [WDG_W:0]        count_out
);
    logic en_d_reg;

    initial begin
        if (WDG_W < 1) $error("WDG_W must be at least 1");
    end

    // edge memory for the enable rise
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) en_d_reg <= 1'b0;
        else          en_d_reg <= enable_in;
    end

    // ==============================
    // counter: setting n gives n+1 seconds, so 0..255 spans 1 s..256 s
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in || !enable_in) begin
            count_out  <= '0;
            expire_out <= 1'b0;
        // RQ15 reload on kick or enable rise
        end else if (kick_in || !en_d_reg) begin
            count_out  <= {1'b0, timeout_in} + (WDG_W+1)'(1);
            expire_out <= 1'b0;
        // RQ20 decrement once per tick
        end else if (tick_in && count_out != '0) begin
            count_out  <= count_out - (WDG_W+1)'(1);
            // RQ12 expiry at zero
            expire_out <= (count_out == (WDG_W+1)'(1));
        end else begin
            expire_out <= 1'b0;
        end
    end
endmodule : fps_watchdog
`default_nettype wire

// File: test_fault_protection_supervisor.sv
// testbench: overcurrent levels 0 to 2, lock release and watchdog expiry
// assumes fps_pkg compiled first; one second is shortened to 10 cycles
`timescale 1ns/1ns
`default_nettype none
module test_fault_protection_supervisor
    import fps_pkg::*;
();
    logic core_clk_in = 1'b0;
    logic rstn_in, restart_request_enable_in, key_clears_lock_flag_in, power_key_long_press_in;
    logic turn_on_request_in, ramp_off_done_in, reset_cycle_in, secondary_power_mode_in;
    logic watchdog_enable_set_in, watchdog_enable_clear_in, watchdog_kick_bit_in;
    logic internal_lock_flag_out, ramp_off_out, supplies_up_out, lock_state_out;
    logic auto_restart_out, watchdog_enable_bit_out;
    logic [7:0] nonvolatile_main_control_shadow_in, watchdog_timeout_setting_in;
    logic [5:0] ldo_overcurrent_in, ldo_turnoff_select_in, irq_ldo_clear_in;
    logic [5:0] pending_irq_reg_three_out, current_limit_out, ldo_overcurrent_off_status_out;
    logic [7:0] buck_overcurrent_in, buck_turnoff_select_in, irq_buck_clear_in;
    logic [7:0] pending_irq_reg_two_out, buck_current_limit_out;
    logic [7:0] buck_switch_overcurrent_off_status_out;
    logic [8:0] watchdog_count_out;
    fps_off_cause_t turnoff_cause_out;
    logic [3:0] ramp_delay;
    int checked = 0;
    int miscompares = 0;

    fps_supervisor #(.TICK_CYCLES(10)) DUT (.*);
    fps_ramp_partner PEER (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .ramp_off_in(ramp_off_out), .delay_in(ramp_delay), .ramp_done_out(ramp_off_done_in));

    always #5 core_clk_in = ~core_clk_in;

    // ==============================
    // shared tasks
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask : cyc

    task automatic conclude();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [15:0] exp, got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    // bounded wait until settled on, or off with no ramp
    task automatic wait_st(input logic up, input string what);
        int i;
        for (i = 0; i < 300; i++) begin
            if (supplies_up_out === up && ramp_off_out === 1'b0) break;
            cyc(1);
        end
        if (i == 300) begin
            chk(what, 16'h0001, 16'h0000);
            conclude();
        end
    endtask : wait_st

    task automatic turn_on();
        turn_on_request_in = 1'b1;
        cyc(1);
        turn_on_request_in = 1'b0;
        wait_st(1'b1, "turn on");
    endtask : turn_on

    // ==============================
    // scenarios
    task automatic t_level0();
        ldo_overcurrent_in = 6'h08;
        buck_overcurrent_in = 8'h80;
        cyc(1);
        chk("limit", 14'h0880, {current_limit_out, buck_current_limit_out});
        {ldo_overcurrent_in, buck_overcurrent_in} = 14'h0000;
        cyc(3);
        chk("stay on", 2'b10, {supplies_up_out, ramp_off_out});
        chk("irq", 14'h0880, {pending_irq_reg_three_out, pending_irq_reg_two_out});
        {irq_ldo_clear_in, irq_buck_clear_in} = 14'h0880;
        cyc(1);
        {irq_ldo_clear_in, irq_buck_clear_in} = 14'h0000;
        cyc(1);
        chk("irq clear", 14'h0000, {pending_irq_reg_three_out, pending_irq_reg_two_out});
        $display("level 0 test done");
    endtask : t_level0

    task automatic sel_off(input logic [5:0] lb, input logic [7:0] bb, input logic [3:0] dl);
        ramp_delay = dl;
        restart_request_enable_in = 1'b1;
        {ldo_turnoff_select_in, buck_turnoff_select_in} = {lb, bb};
        {ldo_overcurrent_in, buck_overcurrent_in} = {lb, bb};
        cyc(1);
        {ldo_overcurrent_in, buck_overcurrent_in} = 14'h0000;
        cyc(1);
        chk("ramp", 1'b1, ramp_off_out);
        chk("cause", FPS_OFF_OVERCURRENT, turnoff_cause_out);
        chk("status", {lb, bb},
            {ldo_overcurrent_off_status_out, buck_switch_overcurrent_off_status_out});
        chk("no restart", 1'b0, auto_restart_out);
        wait_st(1'b0, "ramp end");
        cyc(20);
        chk("idle", 2'b00, {supplies_up_out, ramp_off_out});
        turn_on();
        restart_request_enable_in = 1'b0;
        $display("level 1 test done");
    endtask : sel_off

    task automatic t_lock();
        ramp_delay = 4'h3;
        nonvolatile_main_control_shadow_in = 8'h01;
        {ldo_turnoff_select_in, buck_turnoff_select_in} = 14'h0000;
        ldo_overcurrent_in = 6'h20;
        cyc(1);
        ldo_overcurrent_in = 6'h00;
        cyc(1);
        chk("lock entry", {2'b11, FPS_OFF_OVERCURRENT_LOCK},
            {ramp_off_out, internal_lock_flag_out, turnoff_cause_out});
        wait_st(1'b0, "lock");
        // key press without permission, together with a turn-on try
        {power_key_long_press_in, turn_on_request_in} = 2'b11;
        cyc(1);
        {power_key_long_press_in, turn_on_request_in} = 2'b00;
        cyc(3);
        chk("lock held", 3'b110,
            {lock_state_out, internal_lock_flag_out, supplies_up_out});
        key_clears_lock_flag_in = 1'b1;
        power_key_long_press_in = 1'b1;
        cyc(1);
        power_key_long_press_in = 1'b0;
        cyc(3);
        chk("key release", 2'b00, {lock_state_out, internal_lock_flag_out});
        key_clears_lock_flag_in = 1'b0;
        turn_on();
        buck_overcurrent_in = 8'h01;
        cyc(1);
        buck_overcurrent_in = 8'h00;
        wait_st(1'b0, "relock");
        rstn_in = 1'b0;
        cyc(2);
        rstn_in = 1'b1;
        cyc(1);
        chk("supply reset", 3'b001,
            {lock_state_out, internal_lock_flag_out, supplies_up_out});
        nonvolatile_main_control_shadow_in = 8'h00;
        $display("lock test done");
    endtask : t_lock

    task automatic t_wdg();
        int n;
        restart_request_enable_in = 1'b1;
        secondary_power_mode_in = 1'b1;
        watchdog_timeout_setting_in = 8'h02;
        cyc(30);
        chk("wdg idle", 10'h000, {watchdog_enable_bit_out, watchdog_count_out});
        watchdog_enable_set_in = 1'b1;
        cyc(1);
        watchdog_enable_set_in = 1'b0;
        cyc(2);
        chk("wdg load", 10'h203, {watchdog_enable_bit_out, watchdog_count_out});
        cyc(9);
        chk("wdg tick", 9'h002, watchdog_count_out);
        watchdog_kick_bit_in = 1'b1;
        cyc(1);
        watchdog_kick_bit_in = 1'b0;
        cyc(1);
        chk("kick reload", 9'h003, watchdog_count_out);
        for (n = 0; n < 100 && ramp_off_out !== 1'b1; n++) cyc(1);
        chk("expiry time", 1'b1, n >= 20 && n <= 36);
        if (n == 100) conclude();
        chk("wdg cause", FPS_OFF_WATCHDOG, turnoff_cause_out);
        chk("wdg off", 2'b01, {watchdog_enable_bit_out, auto_restart_out});
        wait_st(1'b1, "auto restart");
        watchdog_timeout_setting_in = 8'hFF;
        watchdog_enable_set_in = 1'b1;
        cyc(1);
        watchdog_enable_set_in = 1'b0;
        cyc(2);
        chk("wdg max", 10'h300, {watchdog_enable_bit_out, watchdog_count_out});
        watchdog_enable_clear_in = 1'b1;
        cyc(1);
        chk("wdg clear", 1'b0, watchdog_enable_bit_out);
        {watchdog_enable_clear_in, watchdog_enable_set_in} = 2'b01;
        cyc(1);
        {watchdog_enable_set_in, reset_cycle_in} = 2'b01;
        cyc(1);
        reset_cycle_in = 1'b0;
        cyc(1);
        chk("reset cycle", 1'b0, watchdog_enable_bit_out);
        {secondary_power_mode_in, restart_request_enable_in} = 2'b00;
        $display("watchdog test done");
    endtask : t_wdg

    // ==============================
    // main sequence
    initial begin
        rstn_in = 1'b0;
        {restart_request_enable_in, key_clears_lock_flag_in, power_key_long_press_in,
         turn_on_request_in, reset_cycle_in, secondary_power_mode_in, watchdog_enable_set_in,
         watchdog_enable_clear_in, watchdog_kick_bit_in} = '0;
        {nonvolatile_main_control_shadow_in, watchdog_timeout_setting_in} = '0;
        {ldo_overcurrent_in, ldo_turnoff_select_in, irq_ldo_clear_in} = '0;
        {buck_overcurrent_in, buck_turnoff_select_in, irq_buck_clear_in} = '0;
        ramp_delay = 4'h0;
        cyc(20);
        rstn_in = 1'b1;
        cyc(1);
        t_level0();
        sel_off(6'h02, 8'h00, 4'h0);
        sel_off(6'h00, 8'h04, 4'h9);
        t_lock();
        t_wdg();
        conclude();
    end
endmodule : test_fault_protection_supervisor
`default_nettype wire
